// ### design/pcie_throughput_monitor.sv
// PCIe transaction-layer and DMA throughput counters with Wishbone access
`timescale 1ns/10ps
module pcie_throughput_monitor
    import perf_mon_pkg::*;
#(
    parameter int unsigned NUM_ENG = 4,
    parameter int unsigned INTERVAL_CYCLES = INTERVAL_CYCLES_DEF
) (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADR_W-1:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic tx_tvalid,
    input wire logic tx_tready,
    input wire logic tx_tlast,
    input wire logic [127:0] tx_tdata,
    input wire logic [BEAT_BYTES-1:0] tx_tkeep,
    input wire logic rx_tvalid,
    input wire logic rx_tready,
    input wire logic rx_tlast,
    input wire logic [127:0] rx_tdata,
    input wire logic [BEAT_BYTES-1:0] rx_tkeep,
    input wire logic [NUM_ENG-1:0] dma_tvalid,
    input wire logic [NUM_ENG-1:0] dma_tready,
    input wire logic [NUM_ENG*BEAT_BYTES-1:0] dma_tkeep
);
    localparam int unsigned NUM_CNT = 4 + NUM_ENG;

    function automatic logic [4:0] keep_bytes(input logic [BEAT_BYTES-1:0] k);
        logic [4:0] n;
        n = 5'h00;
        for (int i = 0; i < BEAT_BYTES; i++) begin
            n = n + 5'(k[i]);
        end
        return n;
    endfunction : keep_bytes

    function automatic logic [12:0] len_bytes(input logic [9:0] len);
        return (len == 10'h000) ? MAX_PAYLOAD_BYTES : {1'b0, len, 2'b00};
    endfunction : len_bytes

    logic [31:0] timer_r;
    logic tick_r;
    logic enable_r;
    logic [15:0] intervals_r;
    logic tx_in_pkt_r;
    logic rx_in_pkt_r;
    logic wb_ack_r;
    logic [31:0] wb_dat_r;
    logic tx_fire;
    logic rx_fire;
    logic tx_sop;
    logic rx_sop;
    logic tx_is_mwr;
    logic rx_is_cpld;
    logic [ADD_W-1:0] add_val [NUM_CNT];
    logic [CNT_W-1:0] snap [NUM_CNT];
    logic bus_req;
    logic [31:0] rd_mux;

    // Interval timer
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            timer_r <= '0;
        end else if (timer_r == INTERVAL_CYCLES - 1) begin
            timer_r <= '0;
        end else begin
            timer_r <= timer_r + 32'h0000_0001;
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            tick_r <= 1'b0;
        end else begin
            tick_r <= (timer_r == INTERVAL_CYCLES - 1);
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            intervals_r <= '0;
        end else if (tick_r) begin
            intervals_r <= intervals_r + 16'h0001;
        end
    end

    // Packet boundaries, so only the first beat is decoded as a header
    assign tx_fire = tx_tvalid && tx_tready;
    assign rx_fire = rx_tvalid && rx_tready;
    assign tx_sop = tx_fire && !tx_in_pkt_r;
    assign rx_sop = rx_fire && !rx_in_pkt_r;

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            tx_in_pkt_r <= 1'b0;
        end else if (tx_fire) begin
            tx_in_pkt_r <= !tx_tlast;
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            rx_in_pkt_r <= 1'b0;
        end else if (rx_fire) begin
            rx_in_pkt_r <= !rx_tlast;
        end
    end

    assign tx_is_mwr = (tx_tdata[31:29] == FMT_3DW_DATA
        || tx_tdata[31:29] == FMT_4DW_DATA) && tx_tdata[28:24] == TYPE_MEM;
    assign rx_is_cpld = rx_tdata[31:29] == FMT_3DW_DATA
        && rx_tdata[28:24] == TYPE_CPL;

    // Byte amounts per cycle; disabled counting feeds zeros
    always_comb begin
        add_val[0] = '0;
        add_val[1] = '0;
        add_val[2] = '0;
        add_val[3] = '0;
        if (enable_r && tx_fire) begin
            add_val[0] = {8'h00, keep_bytes(tx_tkeep)};
        end
        if (enable_r && rx_fire) begin
            add_val[1] = {8'h00, keep_bytes(rx_tkeep)};
        end
        if (enable_r && tx_sop && tx_is_mwr) begin
            add_val[2] = len_bytes(tx_tdata[9:0]);
        end
        if (enable_r && rx_sop && rx_is_cpld) begin
            add_val[3] = len_bytes(rx_tdata[9:0]);
        end
    end

    for (genvar e = 0; e < NUM_ENG; e++) begin : g_eng
        assign add_val[4+e] = (enable_r && dma_tvalid[e] && dma_tready[e])
            ? {8'h00, keep_bytes(dma_tkeep[e*BEAT_BYTES +: BEAT_BYTES])}
            : '0;
    end

    for (genvar c = 0; c < NUM_CNT; c++) begin : g_cnt
        perf_accum u_accum (
            .core_clk(core_clk),
            .resetn(resetn),
            .tick(tick_r),
            .add_val(add_val[c]),
            .snap_r(snap[c])
        );
    end

    // Wishbone slave, one wait state; unmapped reads return zero
    assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_r;

    always_comb begin
        rd_mux = '0;
        unique case (wb_adr_i)
            OFF_TX_UTIL: rd_mux = snap[0];
            OFF_RX_UTIL: rd_mux = snap[1];
            OFF_TX_PAYLOAD: rd_mux = snap[2];
            OFF_RX_PAYLOAD: rd_mux = snap[3];
            OFF_CTRL: rd_mux = {31'h0000_0000, enable_r};
            OFF_STATUS: rd_mux = {16'h0000, intervals_r};
            default: begin
                for (int i = 0; i < NUM_ENG; i++) begin
                    if (wb_adr_i == OFF_DMA_BASE + ADR_W'(4 * i)) begin
                        rd_mux = snap[4+i];
                    end
                end
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            wb_ack_r <= 1'b0;
        end else begin
            wb_ack_r <= bus_req;
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            wb_dat_r <= '0;
        end else if (bus_req && !wb_we_i) begin
            wb_dat_r <= rd_mux;
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            enable_r <= CTRL_ENABLE_RST;
        end else if (bus_req && wb_we_i && wb_sel_i[0]
            && wb_adr_i == OFF_CTRL) begin
            enable_r <= wb_dat_i[0];
        end
    end

    assign wb_ack_o = wb_ack_r;
    assign wb_dat_o = wb_dat_r;

    sequence s_bus_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence

    sequence s_one_ack;
        wb_ack_o ##1 !wb_ack_o;
    endsequence

    a_wb_answer: assert property (@(posedge core_clk) disable iff (!resetn)
        s_bus_req |=> s_one_ack)
        else $error("bus ack not one cycle after request");
    a_tick_spacing: assert property (@(posedge core_clk)
        disable iff (!resetn)
        (timer_r == INTERVAL_CYCLES - 1) |=> tick_r ##1 !tick_r)
        else $error("interval tick misplaced");
    a_tick_only_end: assert property (@(posedge core_clk)
        disable iff (!resetn) tick_r |-> timer_r == '0)
        else $error("tick away from interval end");
    a_tx_util_bytes: assert property (@(posedge core_clk)
        disable iff (!resetn)
        (enable_r && tx_fire && tx_tkeep == 16'hFFFF)
        |-> add_val[0] == 13'h0010)
        else $error("full tx beat not counted as sixteen bytes");
    a_rx_util_idle: assert property (@(posedge core_clk)
        disable iff (!resetn) !rx_fire |-> add_val[1] == '0)
        else $error("rx counted without a beat");
    a_tx_pay_mwr: assert property (@(posedge core_clk)
        disable iff (!resetn) add_val[2] != '0 |-> tx_sop && tx_is_mwr)
        else $error("tx payload counted outside a write header");
    a_rx_pay_cpl: assert property (@(posedge core_clk)
        disable iff (!resetn) add_val[3] != '0 |-> rx_sop && rx_is_cpld)
        else $error("rx payload counted outside a completion header");
    a_dma_partial: assert property (@(posedge core_clk)
        disable iff (!resetn)
        (enable_r && dma_tvalid[0] && dma_tready[0]
        && dma_tkeep[BEAT_BYTES-1:0] == 16'h000F) |-> add_val[4] == 13'h0004)
        else $error("partial dma beat miscounted");
endmodule : pcie_throughput_monitor

// ### design/perf_mon_pkg.sv
// Shared constants for the PCIe throughput monitor
package perf_mon_pkg;
    localparam int unsigned CLK_PERIOD_NS = 40;
    localparam int unsigned INTERVAL_NS = 1_000_000_000;
    localparam int unsigned INTERVAL_CYCLES_DEF = INTERVAL_NS / CLK_PERIOD_NS;
    localparam int unsigned BEAT_BYTES = 16;
    localparam int unsigned CNT_W = 32;
    localparam int unsigned ADD_W = 13;
    localparam int unsigned ADR_W = 8;
    localparam logic [7:0] OFF_TX_UTIL = 8'h00;
    localparam logic [7:0] OFF_RX_UTIL = 8'h04;
    localparam logic [7:0] OFF_TX_PAYLOAD = 8'h08;
    localparam logic [7:0] OFF_RX_PAYLOAD = 8'h0C;
    localparam logic [7:0] OFF_CTRL = 8'h10;
    localparam logic [7:0] OFF_STATUS = 8'h14;
    localparam logic [7:0] OFF_DMA_BASE = 8'h40;
    localparam logic CTRL_ENABLE_RST = 1'b1;
    localparam logic [2:0] FMT_3DW_DATA = 3'h2;
    localparam logic [2:0] FMT_4DW_DATA = 3'h3;
    localparam logic [4:0] TYPE_MEM = 5'h00;
    localparam logic [4:0] TYPE_CPL = 5'h0A;
    localparam logic [12:0] MAX_PAYLOAD_BYTES = 13'h1000;
endpackage : perf_mon_pkg

// ### design/perf_accum.sv
// One interval accumulator with its software-visible snapshot
`timescale 1ns/10ps
module perf_accum
    import perf_mon_pkg::*;
(
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic tick,
    input wire logic [ADD_W-1:0] add_val,
    output logic [CNT_W-1:0] snap_r
);
    logic [CNT_W-1:0] acc_r;
    logic [CNT_W-1:0] acc_nxt;

    assign acc_nxt = acc_r + CNT_W'(add_val);

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            acc_r <= '0;
        end else if (tick) begin
            acc_r <= '0;
        end else begin
            acc_r <= acc_nxt;
        end
    end

    // Last beat of the interval still belongs to it
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            snap_r <= '0;
        end else if (tick) begin
            snap_r <= acc_nxt;
        end
    end

    a_snap_restart: assert property (@(posedge core_clk)
        disable iff (!resetn)
        tick |=> (acc_r == '0)
        && (snap_r == $past(acc_r) + CNT_W'($past(add_val))))
        else $error("snapshot or restart wrong at interval end");
    a_snap_hold: assert property (@(posedge core_clk)
        disable iff (!resetn) !tick |=> $stable(snap_r))
        else $error("snapshot changed mid interval");
    a_acc_sum: assert property (@(posedge core_clk)
        disable iff (!resetn)
        !tick |=> acc_r == $past(acc_r) + CNT_W'($past(add_val)))
        else $error("accumulator lost a count");
endmodule : perf_accum

// ### dv/pcie_stream_model.sv
// Far-side model: PCIe core TX/RX streams and DMA engine streams
`timescale 1ns/10ps
module pcie_stream_model
    import perf_mon_pkg::*;
#(
    parameter int unsigned NUM_ENG = 4
) (
    input wire logic core_clk,
    output logic [NUM_ENG+1:0] valid,
    output logic [NUM_ENG+1:0] ready,
    output logic [NUM_ENG+1:0] last,
    output logic [127:0] tdata,
    output logic [(NUM_ENG+2)*16-1:0] keep
);
    initial begin
        valid = '0;
        ready = '0;
        last = '0;
        tdata = '0;
        keep = '0;
    end

    // Path 0 TX, 1 RX, 2+e DMA engine e; one stalled beat first
    task automatic send(input int p, input logic [31:0] dw0,
                        input int beats, input logic [15:0] lk);
        @(posedge core_clk);
        valid[p] <= 1'b1;
        ready[p] <= 1'b0;
        keep[p*16 +: 16] <= 16'hFFFF;
        tdata <= 128'(dw0);
        for (int i = 0; i < beats; i++) begin
            @(posedge core_clk);
            ready[p] <= 1'b1;
            tdata <= (i == 0) ? 128'(dw0) : {4{~dw0}};
            keep[p*16 +: 16] <= (i == beats - 1) ? lk : 16'hFFFF;
            last[p] <= (i == beats - 1);
        end
        @(posedge core_clk);
        valid[p] <= 1'b0;
        ready[p] <= 1'b0;
        last[p] <= 1'b0;
        // Released lines show garbage, never the last value
        tdata <= ~tdata;
        keep[p*16 +: 16] <= ~keep[p*16 +: 16];
    endtask : send
endmodule : pcie_stream_model

// ### dv/pcie_throughput_monitor_tb.sv
// Self-checking bench for the PCIe throughput monitor
`timescale 1ns/10ps
`define CHK(g, e) check_val(g, e)
module pcie_throughput_monitor_tb
    import perf_mon_pkg::*;
;
    localparam int unsigned NE = 4;
    localparam int unsigned IV = 80;
    logic core_clk = 1'b0;
    logic resetn = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [3:0] sel = '0;
    logic [7:0] adr = '0;
    logic [31:0] wdat = '0;
    logic [31:0] rdat;
    logic ack;
    logic [NE+1:0] sv, sr, sl;
    logic [127:0] sd;
    logic [(NE+2)*16-1:0] sk;
    int fail_count = 0;
    int checks_done = 0;
    int cyc_cnt = 0;

    always #20 core_clk = ~core_clk;

    // Short interval keeps the run small
    pcie_throughput_monitor #(.NUM_ENG(NE), .INTERVAL_CYCLES(IV)) DUT (
        .core_clk(core_clk), .resetn(resetn), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat),
        .wb_sel_i(sel), .wb_dat_o(rdat), .wb_ack_o(ack),
        .tx_tvalid(sv[0]), .tx_tready(sr[0]), .tx_tlast(sl[0]),
        .tx_tdata(sd), .tx_tkeep(sk[15:0]), .rx_tvalid(sv[1]),
        .rx_tready(sr[1]), .rx_tlast(sl[1]), .rx_tdata(sd),
        .rx_tkeep(sk[31:16]), .dma_tvalid(sv[NE+1:2]),
        .dma_tready(sr[NE+1:2]), .dma_tkeep(sk[(NE+2)*16-1:32]));

    pcie_stream_model #(.NUM_ENG(NE)) far (.core_clk(core_clk),
        .valid(sv), .ready(sr), .last(sl), .tdata(sd), .keep(sk));

    task automatic final_report;
        $display("checks_done=%0d fail_count=%0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : final_report

    always @(posedge core_clk) begin
        cyc_cnt++;
        if (cyc_cnt == 3000) begin
            fail_count++;
            final_report();
        end
    end

    task automatic check_val(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e) begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : check_val

    // Entered just after a rising edge; no cycle count assumed
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] r);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        sel <= 4'hF;
        adr <= a;
        wdat <= d;
        do @(posedge core_clk); while (ack !== 1'b1);
        r = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        sel <= 4'h0;
        @(posedge core_clk);
    endtask : wb

    task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] d;
        wb(1'b0, a, '0, d);
        `CHK(d, e);
    endtask : rdchk

    // Polls the interval count until it moves
    task automatic wait_tick(output logic [31:0] s);
        logic [31:0] s0;
        wb(1'b0, OFF_STATUS, '0, s0);
        do wb(1'b0, OFF_STATUS, '0, s); while (s[15:0] === s0[15:0]);
    endtask : wait_tick

    function automatic logic [31:0] hdr(input logic [2:0] f,
                                        input logic [4:0] t,
                                        input logic [9:0] n);
        return {f, t, 14'h0000, n};
    endfunction : hdr

    task automatic t_reset;
        rdchk(OFF_CTRL, 32'h0000_0001);
        rdchk(OFF_TX_UTIL, 32'h0000_0000);
        rdchk(8'h20, 32'h0000_0000);
        $display("test reset done");
    endtask : t_reset

    task automatic t_traffic;
        logic [31:0] s;
        wait_tick(s);
        far.send(0, hdr(FMT_3DW_DATA, TYPE_MEM, 10'h004), 3, 16'h00FF);
        far.send(0, hdr(3'h0, TYPE_MEM, 10'h001), 1, 16'h0FFF);
        far.send(0, hdr(FMT_4DW_DATA, TYPE_MEM, 10'h002), 2, 16'h000F);
        far.send(1, hdr(FMT_3DW_DATA, TYPE_CPL, 10'h000), 2, 16'hFFFF);
        far.send(1, hdr(FMT_3DW_DATA, TYPE_MEM, 10'h001), 1, 16'hFFFF);
        far.send(1, hdr(3'h0, TYPE_CPL, 10'h001), 1, 16'h0FFF);
        for (int e = 0; e < NE; e++)
            far.send(e + 2, '0, e + 1, 16'h000F);
        wait_tick(s);
        rdchk(OFF_TX_UTIL, 32'h0000_0048);
        rdchk(OFF_TX_PAYLOAD, 32'h0000_0018);
        rdchk(OFF_RX_UTIL, 32'h0000_003C);
        rdchk(OFF_RX_PAYLOAD, 32'h0000_1000);
        for (int e = 0; e < NE; e++)
            rdchk(OFF_DMA_BASE + 8'(4 * e), 32'(16 * e + 4));
        $display("test traffic done");
    endtask : t_traffic

    task automatic t_restart;
        logic [31:0] s1, s2;
        wait_tick(s1);
        wb(1'b1, OFF_TX_UTIL, 32'hFFFF_FFFF, s2);
        rdchk(OFF_TX_UTIL, 32'h0000_0000);
        rdchk(OFF_RX_PAYLOAD, 32'h0000_0000);
        rdchk(OFF_DMA_BASE, 32'h0000_0000);
        wait_tick(s2);
        `CHK(32'(s2[15:0]), 32'(s1[15:0] + 16'h0001));
        $display("test restart done");
    endtask : t_restart

    task automatic t_disable;
        logic [31:0] s;
        wb(1'b1, OFF_CTRL, 32'h0000_0000, s);
        rdchk(OFF_CTRL, 32'h0000_0000);
        wait_tick(s);
        far.send(0, hdr(FMT_3DW_DATA, TYPE_MEM, 10'h001), 2, 16'hFFFF);
        wait_tick(s);
        rdchk(OFF_TX_PAYLOAD, 32'h0000_0000);
        rdchk(OFF_TX_UTIL, 32'h0000_0000);
        wb(1'b1, OFF_CTRL, 32'h0000_0001, s);
        rdchk(OFF_CTRL, 32'h0000_0001);
        $display("test disable done");
    endtask : t_disable

    initial begin
        repeat (10) @(posedge core_clk);
        resetn <= 1'b1;
        t_reset();
        t_traffic();
        t_restart();
        t_disable();
        final_report();
    end
endmodule : pcie_throughput_monitor_tb
